// ===== design/watchdog_pkg.sv
/*
 * Shared constants of the watchdog: register indices, field layout, reset values, key bytes
 * and cycle figures.
 * Assumes the bus clock is the oscillator clock, so one oscillator period is one clock cycle.
 */
package watchdog_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] KEY_SERVICE_IDX   = 8'ha6;
   localparam logic [7:0] PERIOD_SELECT_IDX = 8'ha7;
   localparam logic [7:0] STATUS_IDX        = 8'ha8;

   // Key bytes
   localparam logic [7:0] KEY_FIRST  = 8'h1e;
   localparam logic [7:0] KEY_SECOND = 8'he1;

   // Field layout and reset values
   localparam int         PERIOD_SEL_LSB   = 0;
   localparam int         PERIOD_SEL_WIDTH = 3;
   localparam logic [2:0] PERIOD_SEL_RESET = 3'h0;
   localparam logic [7:0] KEY_REG_RESET    = 8'hff;
   localparam int         STAT_ENABLED_BIT = 0;
   localparam int         STAT_HOLD_BIT    = 1;
   localparam int         STAT_ARMED_BIT   = 2;
   localparam int         STAT_STAGE_LSB   = 8;

   // Counter chain
   localparam int PRESCALE_BITS = 14;
   localparam int STAGE_BITS    = 7;

   // Machine cycle length in oscillator periods
   localparam int OSC_PER_MC_STD = 12;
   localparam int OSC_PER_MC_X2  = 6;

   // Oscillator and reset pulse timing
   localparam int OSC_PERIOD_NS        = 20;
   localparam int RESET_PULSE_OSC      = 96;
   localparam int RESET_PULSE_NS       = RESET_PULSE_OSC * OSC_PERIOD_NS;
   localparam int RESET_PULSE_CYCLES   = (RESET_PULSE_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;

endpackage

// ===== design/machine_cycle_tick.sv
/*
 * Machine cycle tick: one-cycle pulse every twelve oscillator periods, or six in
 * double-speed mode. Halts while the oscillator is stopped.
 * Assumes x2_mode_i and osc_run_i are on the same clock.
 */
`timescale 1ns/1ns
module machine_cycle_tick
   import watchdog_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic x2_mode_i,
   input  wire logic osc_run_i,
   output logic      tick_o
);

   logic [3:0] div_q;
   logic [3:0] last;

   assign last = x2_mode_i ? 4'(OSC_PER_MC_X2 - 1) : 4'(OSC_PER_MC_STD - 1);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q  <= 4'h0;
         tick_o <= 1'b0;
      end else if (!osc_run_i) begin
         tick_o <= 1'b0;
      end else if (div_q >= last) begin
         // Also catches a mode switch that leaves the divider past the end
         div_q  <= 4'h0;
         tick_o <= 1'b1;
      end else begin
         div_q  <= div_q + 4'h1;
         tick_o <= 1'b0;
      end
   end

endmodule

// ===== design/reset_pulse_stretch.sv
/*
 * Stretches a one-cycle overflow event into a chip reset pulse of fixed length.
 * Assumes start_i is a pulse on the same clock.
 */
`timescale 1ns/1ns
module reset_pulse_stretch
   import watchdog_pkg::*;
#(
   parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
)
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic start_i,
   output logic      pulse_o
);

   localparam int CW = $clog2(PULSE_CYCLES + 1);

   logic [CW-1:0] left_q;

   // Elaboration-time parameter check
   if (PULSE_CYCLES < 1) begin
      $error("PULSE_CYCLES must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_q  <= '0;
         pulse_o <= 1'b0;
      end else if (start_i) begin
         left_q  <= CW'(PULSE_CYCLES - 1);
         pulse_o <= 1'b1;
      end else if (left_q != '0) begin
         left_q  <= left_q - CW'(1);
         pulse_o <= 1'b1;
      end else begin
         pulse_o <= 1'b0;
      end
   end

endmodule

// ===== design/watchdog_reset_timer.sv
/*
 * Watchdog reset timer with classic Wishbone register access.
 * Assumes clk_i is the oscillator clock, power_down_i and x2_mode_i come from the core on
 * the same clock, and ext_int_n_i is the raw external interrupt pin.
 */
// Implementation choice: the Wishbone slave port.
// Functional notes
// - After any reset the watchdog is disabled and does not count.
// - Writing 1EH then E1H back to back to the key register arms it.
// - The same key pair while running restarts the count from zero.
// - Enabled, the counter advances once per machine cycle while the oscillator runs.
// - No software action disables it; only reset or overflow do.
// - Overflow drives a chip reset pulse of 96 oscillator periods.
// - Counter chain is a 14-bit prescaler then a 7-bit stage.
// - Select value S gives a timeout of 2^(14+S) machine cycles.
// - While enabled, writes cannot change the active period.
// - Select field resets to 000; upper bits reserved, read zero.
// - In power-down the counter holds its value.
// - Leaving power-down by hardware reset leaves the watchdog disabled.
// - After interrupt wake-up counting waits until the interrupt pin is high.
// - In idle the oscillator runs, so the watchdog keeps counting.
// - Key register is write-only at A6h; period register at A7h.
`timescale 1ns/1ns
module watchdog_reset_timer
   import watchdog_pkg::*;
#(
   parameter int PRESCALE_WIDTH = PRESCALE_BITS,
   parameter int STAGE_WIDTH    = STAGE_BITS
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Core and pin side
   input  wire logic        power_down_i,
   input  wire logic        x2_mode_i,
   input  wire logic        ext_int_n_i,
   output logic             chip_reset_o,
   output logic             running_o
);

   localparam int CHAIN_WIDTH = PRESCALE_WIDTH + STAGE_WIDTH;

   // Elaboration-time parameter checks
   if (PRESCALE_WIDTH < 1 || PRESCALE_WIDTH > 24) begin
      $error("PRESCALE_WIDTH out of range");
   end
   if (STAGE_WIDTH != (1 << PERIOD_SEL_WIDTH) - 1) begin
      $error("STAGE_WIDTH must match select field");
   end

   // Ones in the low 14+S bits of the chain mark the terminal count
   function automatic logic [CHAIN_WIDTH-1:0] terminal_mask(input logic [2:0] sel);
      logic [CHAIN_WIDTH-1:0] m;
      m = '0;
      for (int i = 0; i < CHAIN_WIDTH; i++) begin
         if (i < PRESCALE_WIDTH + int'(sel)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic       req;
   logic       wr;
   logic       hit_key;
   logic       hit_period;
   logic       hit_status;
   logic [7:0] idx;

   assign idx        = wb_adr_i[9:2];
   assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr         = req && wb_we_i && wb_sel_i[0];
   assign hit_key    = idx == KEY_SERVICE_IDX;
   assign hit_period = idx == PERIOD_SELECT_IDX;
   assign hit_status = idx == STATUS_IDX;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser

   logic int_meta_q;
   logic int_high_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_meta_q <= 1'b1;
         int_high_q <= 1'b1;
      end else begin
         int_meta_q <= ext_int_n_i;
         int_high_q <= int_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Machine cycle tick

   logic mc_tick;

   machine_cycle_tick u_tick (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .x2_mode_i (x2_mode_i),
      .osc_run_i (!power_down_i),
      .tick_o    (mc_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Key sequence

   logic key_wr;
   logic first_key_q;
   logic key_pair;

   assign key_wr   = wr && hit_key;
   assign key_pair = key_wr && first_key_q && wb_dat_i[7:0] == KEY_SECOND;

   // Any other write to the key register drops a pending first byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_key_q <= 1'b0;
      end else if (key_wr) begin
         first_key_q <= wb_dat_i[7:0] == KEY_FIRST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Period select

   logic [2:0] period_sel_q;
   logic [2:0] active_sel_q;
   logic       enabled_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         period_sel_q <= PERIOD_SEL_RESET;
      end else if (wr && hit_period && !enabled_q) begin
         period_sel_q <= wb_dat_i[PERIOD_SEL_LSB +: PERIOD_SEL_WIDTH];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable, wake hold and counter chain

   logic                   overflow_q;
   logic                   hold_q;
   logic [CHAIN_WIDTH-1:0] chain_q;
   logic                   at_terminal;
   logic                   count_en;

   assign at_terminal = (chain_q & terminal_mask(active_sel_q)) == terminal_mask(active_sel_q);
   assign count_en    = enabled_q && mc_tick && !hold_q;

   // Only reset or overflow clear the enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enabled_q    <= 1'b0;
         active_sel_q <= PERIOD_SEL_RESET;
      end else if (overflow_q) begin
         enabled_q    <= 1'b0;
      end else if (key_pair && !enabled_q) begin
         enabled_q    <= 1'b1;
         active_sel_q <= period_sel_q;
      end
   end

   // Interrupt wake-up: hold until the synchronised pin reads high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_q <= 1'b0;
      end else if (power_down_i) begin
         hold_q <= 1'b1;
      end else if (int_high_q) begin
         hold_q <= 1'b0;
      end
   end

   // Prescaler is the low bits of the chain, stage the high bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chain_q    <= '0;
         overflow_q <= 1'b0;
      end else if (key_pair || overflow_q) begin
         chain_q    <= '0;
         overflow_q <= 1'b0;
      end else if (count_en && at_terminal) begin
         chain_q    <= '0;
         overflow_q <= 1'b1;
      end else if (count_en) begin
         chain_q    <= chain_q + CHAIN_WIDTH'(1);
         overflow_q <= 1'b0;
      end
   end

   // Idle needs no term here: only power-down stops the tick

   ////////////////////////////////////////////////////////////////////////////
   // Chip reset pulse

   reset_pulse_stretch #(
      .PULSE_CYCLES (RESET_PULSE_CYCLES)
   ) u_stretch (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (overflow_q),
      .pulse_o (chip_reset_o)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         running_o <= 1'b0;
      end else begin
         running_o <= enabled_q && !overflow_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer

   logic [31:0] rd_d;

   always_comb begin
      rd_d = 32'h0;
      if (hit_period) begin
         rd_d[PERIOD_SEL_LSB +: PERIOD_SEL_WIDTH] = period_sel_q;
      end else if (hit_status) begin
         rd_d[STAT_ENABLED_BIT] = enabled_q;
         rd_d[STAT_HOLD_BIT]    = hold_q;
         rd_d[STAT_ARMED_BIT]   = first_key_q;
         rd_d[STAT_STAGE_LSB +: STAGE_WIDTH] = chain_q[CHAIN_WIDTH-1 -: STAGE_WIDTH];
      end
      // Key register is write-only and reads zero
   end

   // Every address is acknowledged; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req && !wb_we_i) ? rd_d : 32'h0;
      end
   end

endmodule

// ===== sim/watchdog_reset_timer_asserts.sv
/*
 * Port checker of the watchdog timer.
 * Assumes it is bound to watchdog_reset_timer and sees only its ports.
 */
`timescale 1ns/1ns
module watchdog_reset_timer_asserts
   import watchdog_pkg::*;
#(
   parameter int PRESCALE_WIDTH = 14,
   parameter int STAGE_WIDTH    = 7
)
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [9:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        power_down_i,
   input wire logic        chip_reset_o,
   input wire logic        running_o
);
   logic [7:0] pulse_cnt_q;
   logic [1:0] e1_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence rd_s(logic [7:0] idx);
      take_s ##0 !wb_we_i && wb_adr_i[9:2] == idx;
   endsequence
   // Arming may show on running_o one or two edges after the write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         e1_q <= 2'h0;
      end else begin
         e1_q <= {e1_q[0], wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                  && wb_adr_i[9:2] == KEY_SERVICE_IDX && wb_dat_i[7:0] == KEY_SECOND};
      end
   end
   // Counts high samples of the reset pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || !chip_reset_o) begin
         pulse_cnt_q <= 8'h0;
      end else begin
         pulse_cnt_q <= pulse_cnt_q + 8'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   reset_idle_a: assert property ($fell(rst_i) |-> !running_o && !chip_reset_o)
      else $error("outputs active after reset");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   bus_answer_a: assert property (take_s |=> wb_ack_o)
      else $error("bus request not answered");
   key_read_a: assert property (rd_s(KEY_SERVICE_IDX) |=> wb_dat_o == 32'h0)
      else $error("key register readable");
   period_read_a: assert property (rd_s(PERIOD_SELECT_IDX) |=> wb_dat_o[31:3] == 29'h0)
      else $error("reserved period bits set");
   arm_pair_a: assert property ($rose(running_o) |-> e1_q != 2'h0)
      else $error("enabled without key write");
   no_disable_a: assert property ($fell(running_o) |-> ##[0:2] chip_reset_o)
      else $error("disabled without overflow");
   pulse_len_a: assert property ($fell(chip_reset_o) |-> pulse_cnt_q == 8'h60)
      else $error("reset pulse length wrong");
   pulse_cap_a: assert property (pulse_cnt_q <= 8'h60)
      else $error("reset pulse too long");
   pd_hold_a: assert property (power_down_i [*5] |-> !$rose(chip_reset_o))
      else $error("overflow during power-down");
endmodule
bind watchdog_reset_timer watchdog_reset_timer_asserts #(.PRESCALE_WIDTH(PRESCALE_WIDTH), .STAGE_WIDTH(STAGE_WIDTH))
   i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
          .wb_ack_o, .power_down_i, .chip_reset_o, .running_o);

// ===== sim/watchdog_reset_timer_tb.sv
/*
 * Self-checking bench of the watchdog timer.
 * Assumes a short prescaler, so timeouts are 2^(4+S) machine cycles.
 */
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin mismatches++; \
   $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module watchdog_reset_timer_tb;
   import watchdog_pkg::*;
   localparam int PW = 4;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 0, stb = 0, we = 0, pd = 0, x2 = 0, int_n = 1;
   logic [9:0]  adr = '0;
   logic [31:0] dat = '0;
   logic [3:0]  sel = '0;
   logic [31:0] dat_o, rd;
   logic        ack, chip_rst, running;
   int          mismatches = 0, checks = 0, cnt = 0, mc, t0, w;
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) cnt <= cnt + 1;
   watchdog_reset_timer #(.PRESCALE_WIDTH(PW), .STAGE_WIDTH(STAGE_BITS)) i_watchdog_reset_timer (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .power_down_i(pd),
      .x2_mode_i(x2), .ext_int_n_i(int_n), .chip_reset_o(chip_rst), .running_o(running));
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Unused lanes and address bits carry noise, the design must ignore them
   task automatic bus(input logic w_i, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      {cyc, stb, we} <= {2'b11, w_i};
      adr <= {idx, 2'($urandom)};
      dat <= {24'($urandom), d};
      sel <= {3'($urandom), 1'b1};
      // No limit here: the watchdog process ends a hung bus
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rst_dut();
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic arm();
      bus(1, KEY_SERVICE_IDX, KEY_FIRST);
      bus(1, KEY_SERVICE_IDX, KEY_SECOND);
      t0 = cnt;
   endtask
   // Window covers the unknown phase of the first machine tick
   task automatic expect_reset(input int exp, input int slack);
      int n;
      while (chip_rst !== 1'b1 && cnt - t0 < 20000) @(posedge clk_i);
      n = cnt - t0;
      `CHK("timeout", 1'b1, (n >= exp - mc + 2 - slack && n <= exp + 1 + slack))
      n = 0;
      while (chip_rst === 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      `CHK("pulse", 96, n)
      `CHK("run_after", 1'b0, running)
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h8e5e888e));
      rst_dut();
      `CHK("run_reset", 1'b0, running)
      bus(0, PERIOD_SELECT_IDX, 8'h0);
      `CHK("prd_reset", 32'h0, rd)
      bus(0, KEY_SERVICE_IDX, 8'h0);
      `CHK("key_read", 32'h0, rd)
      bus(1, 8'hff, 8'h5a);
      bus(0, 8'hff, 8'h0);
      `CHK("unmapped", 32'h0, rd)
      bus(1, KEY_SERVICE_IDX, KEY_FIRST);
      bus(1, KEY_SERVICE_IDX, 8'h55);
      bus(1, KEY_SERVICE_IDX, KEY_SECOND);
      repeat (30) @(posedge clk_i);
      `CHK("run_broken", 1'b0, running)
      $display("test keys done");
      for (int s = 0; s < 8; s++) begin
         x2 <= s[0];
         mc = s[0] ? 6 : 12;
         rst_dut();
         bus(1, PERIOD_SELECT_IDX, 8'(s));
         arm();
         bus(1, PERIOD_SELECT_IDX, 8'(s ^ 7));
         bus(1, KEY_SERVICE_IDX, 8'h00);
         bus(0, PERIOD_SELECT_IDX, 8'h0);
         `CHK("prd_locked", 32'(s), rd)
         `CHK("run_armed", 1'b1, running)
         expect_reset((1 << (PW + s)) * mc, 0);
      end
      $display("test periods done");
      // Standard mode from here on
      x2 <= 1'b0;
      mc = 12;
      rst_dut();
      bus(1, PERIOD_SELECT_IDX, 8'h1);
      arm();
      w = 100 + $urandom % 200;
      repeat (w) @(posedge clk_i);
      arm();
      expect_reset(32 * mc, 0);
      $display("test service done");
      rst_dut();
      arm();
      repeat (60) @(posedge clk_i);
      {pd, int_n} <= 2'b10;
      repeat (400) @(posedge clk_i);
      `CHK("run_pd", 1'b1, running)
      pd <= 1'b0;
      repeat (300) @(posedge clk_i);
      `CHK("hold_low", 1'b0, chip_rst)
      `CHK("run_hold", 1'b1, running)
      int_n <= 1'b1;
      t0 = cnt - 61;
      expect_reset(16 * mc, mc + 4);
      // Service just before power-down and again once the pin is released
      arm();
      {pd, int_n} <= 2'b10;
      repeat (50) @(posedge clk_i);
      pd <= 1'b0;
      repeat (20) @(posedge clk_i);
      bus(0, STATUS_IDX, 8'h0);
      `CHK("stat_hold", 32'h3, rd)
      int_n <= 1'b1;
      repeat (10) @(posedge clk_i);
      arm();
      repeat (100) @(posedge clk_i);
      `CHK("run_isr", 1'b1, running)
      pd <= 1'b1;
      rst_dut();
      pd <= 1'b0;
      repeat (40) @(posedge clk_i);
      `CHK("run_pd_rst", 1'b0, running)
      $display("test power_down done");
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      mismatches++;
      stop_test();
   end
endmodule
